// ### aec_interp.sv
`timescale 1ns/100ps
module aec_interp (
  input  aec_pkg::aec_point_t lo_i,
  input  aec_pkg::aec_point_t hi_i,
  input  aec_pkg::aec_pos_t   x_i,
  output aec_pkg::aec_pos_t   err_o
);
  logic signed [63:0] span;
  logic signed [63:0] prod;
  logic signed [63:0] quot;

  always_comb begin
    span = 64'(hi_i.pos) - 64'(lo_i.pos);
    prod = (64'(hi_i.err) - 64'(lo_i.err)) * (64'(x_i) - 64'(lo_i.pos));
    // Equal positions would divide by zero; take the low point
    quot = (span == 64'sh0) ? 64'sh0 : prod / span;
    err_o = lo_i.err + quot[31:0];
  end
endmodule : aec_interp

// ### aec_pkg.sv
package aec_pkg;

  typedef logic signed [31:0] aec_pos_t;

  typedef enum logic [1:0] {
    AEC_MODE_OFF,
    AEC_MODE_LIN,
    AEC_MODE_NLIN
  } aec_mode_t;

  typedef enum logic [1:0] {
    AEC_ST_IDLE,
    AEC_ST_SCAN,
    AEC_ST_SHIFT
  } aec_state_t;

  typedef struct packed {
    aec_pos_t pos;
    aec_pos_t err;
  } aec_point_t;

  typedef struct packed {
    aec_mode_t mode;
    logic      enc_linear;
    logic      has_ref;
    logic      ref_seen;
    aec_pos_t  ppm;
    aec_pos_t  datum;
    aec_pos_t  refpt;
  } aec_axis_t;

endpackage : aec_pkg

// ### aec_regs.svh
`ifndef AEC_REGS_SVH
`define AEC_REGS_SVH

// Register byte addresses
`define AEC_ADDR_AXIS_SEL   8'h00
`define AEC_ADDR_CTRL       8'h04
`define AEC_ADDR_PPM        8'h08
`define AEC_ADDR_ENTRY_POS  8'h0c
`define AEC_ADDR_ENTRY_ERR  8'h10
`define AEC_ADDR_REF_LEN    8'h14
`define AEC_ADDR_STYLUS     8'h18
`define AEC_ADDR_CMD        8'h1c
`define AEC_ADDR_STATUS     8'h20
`define AEC_ADDR_MEASURED   8'h24
`define AEC_ADDR_DATUM      8'h28
`define AEC_ADDR_EXP_POS    8'h2c
`define AEC_ADDR_EXP_ERR    8'h30
`define AEC_ADDR_CORR_POS   8'h34

// CTRL fields
`define AEC_CTRL_MODE_LO    0
`define AEC_CTRL_MODE_HI    1
`define AEC_CTRL_ENC_LIN    2
`define AEC_CTRL_HAS_REF    3

// CTRL mode field codes
`define AEC_MODE_CODE_OFF   2'h0
`define AEC_MODE_CODE_LIN   2'h1
`define AEC_MODE_CODE_NLIN  2'h2

// CMD bits, one-shot actions on write; OPPOSITE acts only as a qualifier of a use in the same write
`define AEC_CMD_START       0
`define AEC_CMD_END         1
`define AEC_CMD_USE         2
`define AEC_CMD_CONFIRM     3
`define AEC_CMD_CANCEL      4
`define AEC_CMD_CLEAR       5
`define AEC_CMD_SET_DATUM   6
`define AEC_CMD_IMPORT      7
`define AEC_CMD_EXPORT      8
`define AEC_CMD_OPPOSITE    9

// STATUS fields
`define AEC_STAT_MEASURING  0
`define AEC_STAT_BUSY       1
`define AEC_STAT_REF_SEEN   2
`define AEC_STAT_IMPORT     3
`define AEC_STAT_EXPORT     4
`define AEC_STAT_CNT_LO     8

// Reset values and scale
`define AEC_RST_WORD        32'h0000_0000
`define AEC_RST_ENC_LIN     1'b1
`define AEC_PPM_SCALE       64'sd1000000

`endif

// ### aec_scale_model.sv
`timescale 1ns/100ps
module aec_scale_model #(
  parameter int NUM_AXES = 6,
  parameter int STEP     = 4,
  parameter int REF_POS  = 512
) (
  input  wire logic                             clk_sys_i,
  input  wire logic                             rst_n_i,
  input  wire aec_pkg::aec_pos_t [NUM_AXES-1:0] tgt_i,
  output aec_pkg::aec_pos_t [NUM_AXES-1:0]      raw_pos_o,
  output logic [NUM_AXES-1:0]                   ref_mark_o
);
  // A scale cannot jump, so the count slews toward the target
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_pos_o <= '0;
    end else begin
      for (int a = 0; a < NUM_AXES; a++) begin
        if (tgt_i[a] > raw_pos_o[a] + STEP) raw_pos_o[a] <= raw_pos_o[a] + STEP;
        else if (tgt_i[a] < raw_pos_o[a] - STEP) raw_pos_o[a] <= raw_pos_o[a] - STEP;
        else raw_pos_o[a] <= tgt_i[a];
      end
    end
  end

  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) ref_mark_o[a] = raw_pos_o[a] == REF_POS;
  end
endmodule : aec_scale_model

// ### aec_top.sv
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "aec_regs.svh"

// Functional notes
// - Every axis keeps its own mode, factor, datum and table, untouched by the others.
// - Axes not marked as linear encoders pass their raw position unchanged.
// - The computed factor is (reference minus measured) over measured, times one million.
// - A ppm value written directly replaces the linear factor.
// - Start clears the measured distance to 0, which then follows the scale until end freezes it.
// - Use computes compensation from the reference, adding the stylus diameter for opposite approach.
// - Each axis holds up to 128 table points pairing measured position with error.
// - Between two adjacent points the error is linearly interpolated.
// - Non-linear mode needs a reference-mark scale and corrects nothing until the mark is crossed.
// - A table error is reference position minus measured position at that measured position.
// - Table positions are taken relative to the axis table datum.
// - Clearing a table moves its datum to the scale reference point.
// - Set-datum moves the table datum to the current position, used for all later entries.
// - Import only on an empty table, export only on a filled one, clear only with data.
// - A point is added on confirm, or on use in non-linear mode; cancel leaves the table as it was.
module aec_top #(
  parameter int NUM_AXES = 6,
  parameter int POINTS   = 128
) (
  input  wire logic                                 clk_sys_i,
  input  wire logic                                 rst_n_i,
  input  wire logic                                 ce_i,
  input  wire logic [7:0]                           reg_addr_i,
  input  wire logic [31:0]                          reg_wdata_i,
  input  wire logic                                 reg_wr_i,
  input  wire logic                                 reg_rd_i,
  output logic [31:0]                               reg_rdata_o,
  input  wire aec_pkg::aec_pos_t [NUM_AXES-1:0]     raw_pos_i,
  input  wire logic [NUM_AXES-1:0]                  ref_mark_i,
  output aec_pkg::aec_pos_t [NUM_AXES-1:0]          corr_pos_o
);
  localparam int AW = $clog2(NUM_AXES);
  localparam int IW = $clog2(POINTS);
  localparam int CW = $clog2(POINTS + 1);

  initial begin
    if (NUM_AXES < 2 || NUM_AXES > 16 || POINTS < 2 || POINTS > 128)
      $error("aec_top: NUM_AXES 2..16 and POINTS 2..128 only");
  end

  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  aec_pkg::aec_point_t tbl [NUM_AXES][POINTS];

  aec_pkg::aec_axis_t  cfg_r [NUM_AXES];
  aec_pkg::aec_axis_t  cfg_nxt [NUM_AXES];
  logic [CW-1:0]       cnt_r [NUM_AXES];
  logic [CW-1:0]       cnt_nxt [NUM_AXES];
  aec_pkg::aec_pos_t   err_r [NUM_AXES];
  aec_pkg::aec_pos_t   err_nxt [NUM_AXES];
  aec_pkg::aec_pos_t   corr_r [NUM_AXES];
  aec_pkg::aec_pos_t   corr_nxt [NUM_AXES];

  logic [AW-1:0]       sel_r, sel_nxt;
  aec_pkg::aec_pos_t   entry_pos_r, entry_pos_nxt;
  aec_pkg::aec_pos_t   entry_err_r, entry_err_nxt;
  aec_pkg::aec_pos_t   ref_len_r, ref_len_nxt;
  aec_pkg::aec_pos_t   stylus_r, stylus_nxt;
  aec_pkg::aec_pos_t   start_pos_r, start_pos_nxt;
  aec_pkg::aec_pos_t   measured_r, measured_nxt;
  logic                measuring_r, measuring_nxt;
  logic                import_r, import_nxt;
  logic                export_r, export_nxt;
  logic [IW-1:0]       exp_ptr_r, exp_ptr_nxt;
  logic [31:0]         rdata_r, rdata_nxt;

  aec_pkg::aec_state_t st_r, st_nxt;
  logic [AW-1:0]       eng_ax_r, eng_ax_nxt;
  logic [CW-1:0]       idx_r, idx_nxt;
  aec_pkg::aec_point_t prev_r, prev_nxt;
  logic                ins_pend_r, ins_pend_nxt;
  logic [AW-1:0]       ins_ax_r, ins_ax_nxt;
  aec_pkg::aec_point_t new_pt_r, new_pt_nxt;

  logic                mem_we;
  logic [AW-1:0]       mem_ax;
  logic [IW-1:0]       mem_idx;
  aec_pkg::aec_point_t mem_wd;

  aec_pkg::aec_point_t scan_pt;
  aec_pkg::aec_point_t shift_pt;
  aec_pkg::aec_pos_t   scan_rel;
  aec_pkg::aec_pos_t   interp_err;
  logic [31:0]         cmd;
  logic                busy;
  logic signed [63:0]  ref_total;
  logic signed [63:0]  factor;
  logic signed [63:0]  lin_prod;

  assign scan_pt  = tbl[eng_ax_r][idx_r[IW-1:0]];
  assign shift_pt = tbl[ins_ax_r][IW'(idx_r - CW'(1))];
  assign scan_rel = raw_pos_i[eng_ax_r] - cfg_r[eng_ax_r].datum;
  assign busy     = ins_pend_r;

  aec_interp u_interp (
    .lo_i  (prev_r),
    .hi_i  (scan_pt),
    .x_i   (scan_rel),
    .err_o (interp_err)
  );

  always_comb begin
    cfg_nxt       = cfg_r;
    cnt_nxt       = cnt_r;
    err_nxt       = err_r;
    sel_nxt       = sel_r;
    entry_pos_nxt = entry_pos_r;
    entry_err_nxt = entry_err_r;
    ref_len_nxt   = ref_len_r;
    stylus_nxt    = stylus_r;
    start_pos_nxt = start_pos_r;
    measured_nxt  = measured_r;
    measuring_nxt = measuring_r;
    import_nxt    = import_r;
    export_nxt    = export_r;
    exp_ptr_nxt   = exp_ptr_r;
    rdata_nxt     = `AEC_RST_WORD;
    st_nxt        = st_r;
    eng_ax_nxt    = eng_ax_r;
    idx_nxt       = idx_r;
    prev_nxt      = prev_r;
    ins_pend_nxt  = ins_pend_r;
    ins_ax_nxt    = ins_ax_r;
    new_pt_nxt    = new_pt_r;
    mem_we        = 1'b0;
    mem_ax        = ins_ax_r;
    mem_idx       = idx_r[IW-1:0];
    mem_wd        = new_pt_r;
    cmd           = reg_wr_i && reg_addr_i == `AEC_ADDR_CMD ? reg_wdata_i : `AEC_RST_WORD;
    // stylus diameter joins the reference for opposite approach
    ref_total     = 64'(ref_len_r) + (cmd[`AEC_CMD_OPPOSITE] ? 64'(stylus_r) : 64'sh0);
    // (S - M) / M scaled to ppm
    factor        = (measured_r == '0) ? 64'sh0 :
                    ((ref_total - 64'(measured_r)) * `AEC_PPM_SCALE) / 64'(measured_r);

    for (int a = 0; a < NUM_AXES; a++) begin
      // mark crossing recorded, reference point latched
      if (ref_mark_i[a]) begin
        cfg_nxt[a].ref_seen = 1'b1;
        cfg_nxt[a].refpt    = raw_pos_i[a];
      end
    end

    // distance follows the scale until end
    if (measuring_r)
      measured_nxt = raw_pos_i[sel_r] - start_pos_r;

    if (reg_wr_i) begin
      case (reg_addr_i)
        `AEC_ADDR_AXIS_SEL: if (!measuring_r) sel_nxt = reg_wdata_i[AW-1:0];
        `AEC_ADDR_CTRL: begin
          // settings land on the selected axis only
          cfg_nxt[sel_r].enc_linear = reg_wdata_i[`AEC_CTRL_ENC_LIN];
          cfg_nxt[sel_r].has_ref    = reg_wdata_i[`AEC_CTRL_HAS_REF];
          case (reg_wdata_i[`AEC_CTRL_MODE_HI:`AEC_CTRL_MODE_LO])
            `AEC_MODE_CODE_LIN:  cfg_nxt[sel_r].mode = aec_pkg::AEC_MODE_LIN;
            `AEC_MODE_CODE_NLIN: if (reg_wdata_i[`AEC_CTRL_HAS_REF]) cfg_nxt[sel_r].mode = aec_pkg::AEC_MODE_NLIN;
            default:             cfg_nxt[sel_r].mode = aec_pkg::AEC_MODE_OFF;
          endcase
        end
        `AEC_ADDR_PPM:       cfg_nxt[sel_r].ppm = reg_wdata_i;
        `AEC_ADDR_ENTRY_POS: entry_pos_nxt = reg_wdata_i;
        `AEC_ADDR_ENTRY_ERR: entry_err_nxt = reg_wdata_i;
        `AEC_ADDR_REF_LEN:   ref_len_nxt = reg_wdata_i;
        `AEC_ADDR_STYLUS:    stylus_nxt = reg_wdata_i;
        default: ;
      endcase
    end

    if (cmd[`AEC_CMD_START]) begin
      start_pos_nxt = raw_pos_i[sel_r];
      measured_nxt  = '0;
      measuring_nxt = 1'b1;
    end else if (cmd[`AEC_CMD_END]) begin
      measuring_nxt = 1'b0;
    end

    if (cmd[`AEC_CMD_USE] && !measuring_r) begin
      if (cfg_r[sel_r].mode == aec_pkg::AEC_MODE_LIN) begin
        cfg_nxt[sel_r].ppm = factor[31:0];
      end else if (cfg_r[sel_r].mode == aec_pkg::AEC_MODE_NLIN && !busy && cnt_r[sel_r] != CW'(POINTS)) begin
        // error is reference minus measured at the end position
        new_pt_nxt.pos = start_pos_r + measured_r - cfg_r[sel_r].datum;
        new_pt_nxt.err = ref_total[31:0] - measured_r;
        ins_pend_nxt   = 1'b1;
        ins_ax_nxt     = sel_r;
      end
    end

    // confirm adds, as does use in non-linear mode; full table refuses
    if (cmd[`AEC_CMD_CONFIRM] && !busy && cnt_r[sel_r] != CW'(POINTS)) begin
      new_pt_nxt.pos = entry_pos_r;
      new_pt_nxt.err = entry_err_r;
      ins_pend_nxt   = 1'b1;
      ins_ax_nxt     = sel_r;
    end
    if (cmd[`AEC_CMD_CANCEL]) begin
      entry_pos_nxt = '0;
      entry_err_nxt = '0;
      import_nxt    = 1'b0;
    end

    if (cmd[`AEC_CMD_CLEAR] && !busy && cnt_r[sel_r] != '0) begin
      cnt_nxt[sel_r] = '0;
      cfg_nxt[sel_r].datum = cfg_r[sel_r].refpt;
      export_nxt = 1'b0;
    end
    if (cmd[`AEC_CMD_SET_DATUM] && !busy)
      cfg_nxt[sel_r].datum = raw_pos_i[sel_r];
    // import on empty, export on filled
    if (cmd[`AEC_CMD_IMPORT] && cnt_r[sel_r] == '0)
      import_nxt = 1'b1;
    if (cmd[`AEC_CMD_EXPORT] && cnt_r[sel_r] != '0) begin
      export_nxt  = 1'b1;
      exp_ptr_nxt = '0;
    end

    if (reg_rd_i) begin
      case (reg_addr_i)
        `AEC_ADDR_AXIS_SEL:  rdata_nxt = 32'(sel_r);
        `AEC_ADDR_CTRL:      rdata_nxt = {28'h0, cfg_r[sel_r].has_ref, cfg_r[sel_r].enc_linear, cfg_r[sel_r].mode};
        `AEC_ADDR_PPM:       rdata_nxt = cfg_r[sel_r].ppm;
        `AEC_ADDR_ENTRY_POS: rdata_nxt = entry_pos_r;
        `AEC_ADDR_ENTRY_ERR: rdata_nxt = entry_err_r;
        `AEC_ADDR_REF_LEN:   rdata_nxt = ref_len_r;
        `AEC_ADDR_STYLUS:    rdata_nxt = stylus_r;
        `AEC_ADDR_STATUS:    rdata_nxt = {16'h0, 8'(cnt_r[sel_r]), 3'h0, export_r, import_r,
                                          cfg_r[sel_r].ref_seen, busy, measuring_r};
        `AEC_ADDR_MEASURED:  rdata_nxt = measured_r;
        `AEC_ADDR_DATUM:     rdata_nxt = cfg_r[sel_r].datum;
        `AEC_ADDR_EXP_POS:   rdata_nxt = export_r ? tbl[sel_r][exp_ptr_r].pos : `AEC_RST_WORD;
        `AEC_ADDR_EXP_ERR: begin
          rdata_nxt = export_r ? tbl[sel_r][exp_ptr_r].err : `AEC_RST_WORD;
          // Reading the error steps to the next point
          if (export_r) begin
            if (CW'(exp_ptr_r) + CW'(1) >= cnt_r[sel_r])
              export_nxt = 1'b0;
            else
              exp_ptr_nxt = exp_ptr_r + IW'(1);
          end
        end
        `AEC_ADDR_CORR_POS:  rdata_nxt = corr_r[sel_r];
        default:             rdata_nxt = `AEC_RST_WORD;
      endcase
    end

    case (st_r)
      aec_pkg::AEC_ST_IDLE: begin
        if (ins_pend_r) begin
          st_nxt  = aec_pkg::AEC_ST_SHIFT;
          idx_nxt = cnt_r[ins_ax_r];
        end else if (cfg_r[eng_ax_r].mode == aec_pkg::AEC_MODE_NLIN && cnt_r[eng_ax_r] != '0) begin
          st_nxt  = aec_pkg::AEC_ST_SCAN;
          idx_nxt = '0;
        end else begin
          err_nxt[eng_ax_r] = '0;
          eng_ax_nxt = (eng_ax_r == AW'(NUM_AXES - 1)) ? '0 : eng_ax_r + AW'(1);
        end
      end
      aec_pkg::AEC_ST_SCAN: begin
        // Table may shrink under the scan after a clear
        if (idx_r >= cnt_r[eng_ax_r]) begin
          err_nxt[eng_ax_r] = '0;
          st_nxt = aec_pkg::AEC_ST_IDLE;
        end else if (scan_rel <= scan_pt.pos) begin
          // below range takes first point error
          err_nxt[eng_ax_r] = (idx_r == '0) ? scan_pt.err : interp_err;
          st_nxt = aec_pkg::AEC_ST_IDLE;
        end else if (idx_r == cnt_r[eng_ax_r] - CW'(1)) begin
          // above range takes last point error
          err_nxt[eng_ax_r] = scan_pt.err;
          st_nxt = aec_pkg::AEC_ST_IDLE;
        end else begin
          prev_nxt = scan_pt;
          idx_nxt  = idx_r + CW'(1);
        end
        if (st_nxt == aec_pkg::AEC_ST_IDLE)
          eng_ax_nxt = (eng_ax_r == AW'(NUM_AXES - 1)) ? '0 : eng_ax_r + AW'(1);
      end
      aec_pkg::AEC_ST_SHIFT: begin
        mem_we = 1'b1;
        if (idx_r != '0 && shift_pt.pos > new_pt_r.pos) begin
          mem_wd  = shift_pt;
          idx_nxt = idx_r - CW'(1);
        end else begin
          // count grows up to the table size
          cnt_nxt[ins_ax_r] = cnt_r[ins_ax_r] + CW'(1);
          ins_pend_nxt = 1'b0;
          st_nxt = aec_pkg::AEC_ST_IDLE;
        end
      end
      default: st_nxt = aec_pkg::AEC_ST_IDLE;
    endcase

    for (int a = 0; a < NUM_AXES; a++) begin
      lin_prod    = 64'(raw_pos_i[a]) * 64'(cfg_r[a].ppm) / `AEC_PPM_SCALE;
      corr_nxt[a] = raw_pos_i[a];
      if (cfg_r[a].enc_linear) begin
        if (cfg_r[a].mode == aec_pkg::AEC_MODE_LIN)
          corr_nxt[a] = raw_pos_i[a] + lin_prod[31:0];
        // nothing before the mark is crossed
        else if (cfg_r[a].mode == aec_pkg::AEC_MODE_NLIN && cfg_r[a].ref_seen)
          corr_nxt[a] = raw_pos_i[a] + err_r[a];
      end
    end
  end

  // Table array has no reset; the count guards it
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && mem_we)
      tbl[mem_ax][mem_idx] <= mem_wd;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        cfg_r[a]  <= '{mode: aec_pkg::AEC_MODE_OFF, enc_linear: `AEC_RST_ENC_LIN, default: '0};
        cnt_r[a]  <= '0;
        err_r[a]  <= '0;
        corr_r[a] <= '0;
      end
      sel_r       <= '0;
      entry_pos_r <= '0;
      entry_err_r <= '0;
      ref_len_r   <= '0;
      stylus_r    <= '0;
      start_pos_r <= '0;
      measured_r  <= '0;
      measuring_r <= 1'b0;
      import_r    <= 1'b0;
      export_r    <= 1'b0;
      exp_ptr_r   <= '0;
      rdata_r     <= '0;
      st_r        <= aec_pkg::AEC_ST_IDLE;
      eng_ax_r    <= '0;
      idx_r       <= '0;
      prev_r      <= '0;
      ins_pend_r  <= 1'b0;
      ins_ax_r    <= '0;
      new_pt_r    <= '0;
    end else if (ce_i) begin
      cfg_r       <= cfg_nxt;
      cnt_r       <= cnt_nxt;
      err_r       <= err_nxt;
      corr_r      <= corr_nxt;
      sel_r       <= sel_nxt;
      entry_pos_r <= entry_pos_nxt;
      entry_err_r <= entry_err_nxt;
      ref_len_r   <= ref_len_nxt;
      stylus_r    <= stylus_nxt;
      start_pos_r <= start_pos_nxt;
      measured_r  <= measured_nxt;
      measuring_r <= measuring_nxt;
      import_r    <= import_nxt;
      export_r    <= export_nxt;
      exp_ptr_r   <= exp_ptr_nxt;
      rdata_r     <= rdata_nxt;
      st_r        <= st_nxt;
      eng_ax_r    <= eng_ax_nxt;
      idx_r       <= idx_nxt;
      prev_r      <= prev_nxt;
      ins_pend_r  <= ins_pend_nxt;
      ins_ax_r    <= ins_ax_nxt;
      new_pt_r    <= new_pt_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++)
      corr_pos_o[a] = corr_r[a];
  end
endmodule : aec_top

// ### aec_top_sva.sv
`timescale 1ns/100ps
`include "aec_regs.svh"
module aec_top_sva #(
  parameter int NUM_AXES = 6,
  parameter int POINTS   = 128
) (
  input wire logic                             clk_sys_i,
  input wire logic                             rst_n_i,
  input wire logic                             ce_i,
  input wire logic [7:0]                       reg_addr_i,
  input wire logic [31:0]                      reg_wdata_i,
  input wire logic                             reg_wr_i,
  input wire logic                             reg_rd_i,
  input wire logic [31:0]                      reg_rdata_o,
  input wire aec_pkg::aec_pos_t [NUM_AXES-1:0] raw_pos_i,
  input wire logic [NUM_AXES-1:0]              ref_mark_i,
  input wire aec_pkg::aec_pos_t [NUM_AXES-1:0] corr_pos_o
);
  logic [1:0]                  up_r;
  logic [3:0]                  sel_r;
  logic [NUM_AXES-1:0][1:0]    mode_r;
  logic [NUM_AXES-1:0]         enc_r;
  logic [NUM_AXES-1:0]         seen_r;
  logic [NUM_AXES-1:0]         known_r;
  aec_pkg::aec_pos_t [NUM_AXES-1:0] ppm_r;
  wire logic                   wr_c = ce_i && reg_wr_i;
  wire logic                   st_c = ce_i && reg_rd_i && reg_addr_i == `AEC_ADDR_STATUS;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  function automatic aec_pkg::aec_pos_t lin_f(input aec_pkg::aec_pos_t r, input aec_pkg::aec_pos_t p);
    return r + aec_pkg::aec_pos_t'(64'(r) * 64'(p) / `AEC_PPM_SCALE);
  endfunction : lin_f

  // Shadow state; computed factors not tracked
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_r    <= 2'h0;
      sel_r   <= 4'h0;
      mode_r  <= '0;
      enc_r   <= '1;
      seen_r  <= '0;
      known_r <= '0;
      ppm_r   <= '0;
    end else begin
      if (up_r != 2'h3) up_r <= up_r + 2'h1;
      seen_r <= seen_r | ref_mark_i;
      if (wr_c && reg_addr_i == `AEC_ADDR_AXIS_SEL) sel_r <= reg_wdata_i[3:0];
      if (wr_c && reg_addr_i == `AEC_ADDR_CTRL) begin
        enc_r[sel_r] <= reg_wdata_i[`AEC_CTRL_ENC_LIN];
        if (reg_wdata_i[1:0] != `AEC_MODE_CODE_NLIN || reg_wdata_i[`AEC_CTRL_HAS_REF]) begin
          mode_r[sel_r] <= reg_wdata_i[1:0];
        end
      end
      if (wr_c && reg_addr_i == `AEC_ADDR_PPM) begin
        ppm_r[sel_r]   <= reg_wdata_i;
        known_r[sel_r] <= 1'b1;
      end
      if (wr_c && reg_addr_i == `AEC_ADDR_CMD && reg_wdata_i[`AEC_CMD_USE]) known_r[sel_r] <= 1'b0;
    end
  end

  for (genvar a = 0; a < NUM_AXES; a++) begin : g_ax
    wire logic raw_c = mode_r[a] == `AEC_MODE_CODE_OFF || !enc_r[a];
    wire logic nl_c  = mode_r[a] == `AEC_MODE_CODE_NLIN && enc_r[a] && !seen_r[a];
    wire logic lin_c = mode_r[a] == `AEC_MODE_CODE_LIN && enc_r[a] && known_r[a];
    a_raw_pass: assert property (
      up_r == 2'h3 && ce_i && raw_c ##1 raw_c
      |-> corr_pos_o[a] == $past(raw_pos_i[a])) else $error("raw passthrough wrong");
    a_nlin_wait: assert property (
      up_r == 2'h3 && ce_i && nl_c ##1 nl_c
      |-> corr_pos_o[a] == $past(raw_pos_i[a])) else $error("correction before reference mark");
    a_lin_scale: assert property (
      up_r == 2'h3 && ce_i && lin_c ##1 lin_c && $stable(ppm_r[a])
      |-> corr_pos_o[a] == lin_f($past(raw_pos_i[a]), ppm_r[a])) else $error("linear correction wrong");
  end

  a_rdata_idle: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 32'h0) else $error("stray read data");
  a_ppm_back: assert property (
    wr_c && reg_addr_i == `AEC_ADDR_PPM ##1 !reg_wr_i ##1 ce_i && reg_rd_i && reg_addr_i == `AEC_ADDR_PPM
    |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("direct factor not kept");
  a_start_zero: assert property (
    wr_c && reg_addr_i == `AEC_ADDR_CMD && reg_wdata_i[`AEC_CMD_START] ##1 !reg_wr_i && $stable(raw_pos_i[sel_r])
    ##1 ce_i && reg_rd_i && reg_addr_i == `AEC_ADDR_MEASURED
    |=> reg_rdata_o == 32'h0) else $error("measured not cleared");
  a_count_max: assert property (
    $past(st_c) |-> reg_rdata_o[15:8] <= POINTS) else $error("count above size");
  a_export_gate: assert property (
    $past(st_c) && reg_rdata_o[`AEC_STAT_EXPORT] |-> reg_rdata_o[15:8] != 8'h0) else $error("export on empty table");
endmodule : aec_top_sva

bind aec_top aec_top_sva #(.NUM_AXES(NUM_AXES), .POINTS(POINTS)) i_sva (.clk_sys_i, .rst_n_i, .ce_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .raw_pos_i, .ref_mark_i, .corr_pos_o);

// ### axis_error_compensation_bench.sv
`timescale 1ns/100ps
`include "aec_regs.svh"
module axis_error_compensation_bench;
  logic                  clk_sys_i   = 1'b0;
  logic                  rst_n_i     = 1'b0;
  logic [7:0]            reg_addr_i  = 8'h00;
  logic [31:0]           reg_wdata_i = 32'h0;
  logic                  reg_wr_i    = 1'b0;
  logic                  reg_rd_i    = 1'b0;
  logic [31:0]           reg_rdata_o;
  aec_pkg::aec_pos_t [5:0] tgt = '0;
  aec_pkg::aec_pos_t [5:0] raw_pos;
  aec_pkg::aec_pos_t [5:0] corr_pos;
  logic [5:0]            ref_mark;
  int                    failures    = 0;
  int                    check_count = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  aec_top i_dut (.clk_sys_i, .rst_n_i, .ce_i(1'b1), .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .raw_pos_i(raw_pos), .ref_mark_i(ref_mark), .corr_pos_o(corr_pos));
  aec_scale_model i_scale (.clk_sys_i, .rst_n_i, .tgt_i(tgt), .raw_pos_o(raw_pos), .ref_mark_o(ref_mark));

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Idle edge so back-to-back writes never drive the strobe twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr

  task automatic cm(input logic [31:0] d);
    wr(`AEC_ADDR_CMD, d);
  endtask : cm

  // Read data stand one cycle only; taken mid-cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    @(negedge clk_sys_i);
    d = reg_rdata_o;
    @(posedge clk_sys_i);
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, d, e);
  endtask : rc

  task automatic rs(input logic [31:0] e, input string nm);
    rc(`AEC_ADDR_STATUS, e, nm);
  endtask : rs

  task automatic mv(input int ax, input aec_pkg::aec_pos_t p);
    tgt[ax] <= p;
    for (int i = 0; i < 30000 && raw_pos[ax] !== p; i++) @(posedge clk_sys_i);
    repeat (20) @(posedge clk_sys_i);
  endtask : mv

  // Bounded wait on busy
  task automatic pt(input logic [31:0] p, input logic [31:0] e);
    logic [31:0] s;
    wr(`AEC_ADDR_ENTRY_POS, p);
    wr(`AEC_ADDR_ENTRY_ERR, e);
    cm(32'h8);
    for (int i = 0; i < 200; i++) begin
      rd(`AEC_ADDR_STATUS, s);
      if (s[`AEC_STAT_BUSY] === 1'b0) break;
    end
  endtask : pt

  initial begin
    #400000;
    failures++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rc(`AEC_ADDR_CTRL, 32'h4, "ctrl reset");
    rs(32'h0, "status reset");
    rc(8'h3c, 32'h0, "unmapped");
    wr(`AEC_ADDR_CTRL, 32'h1);
    wr(`AEC_ADDR_PPM, 32'h3e8);
    wr(`AEC_ADDR_AXIS_SEL, 32'h1);
    wr(`AEC_ADDR_CTRL, 32'h5);
    wr(`AEC_ADDR_PPM, 32'h3e8);
    rc(`AEC_ADDR_PPM, 32'h3e8, "ppm direct");
    wr(`AEC_ADDR_AXIS_SEL, 32'h2);
    wr(`AEC_ADDR_CTRL, 32'h5);
    wr(`AEC_ADDR_PPM, 32'hfffffe0c);
    tgt[0] <= 32'h4e20;
    tgt[1] <= 32'h4e20;
    mv(2, 32'h4e20);
    chk("corr angular", corr_pos[0], 32'h4e20);
    chk("corr plus", corr_pos[1], 32'h4e34);
    chk("corr minus", corr_pos[2], 32'h4e16);
    wr(`AEC_ADDR_AXIS_SEL, 32'h1);
    cm(32'h1);
    rc(`AEC_ADDR_MEASURED, 32'h0, "measured start");
    mv(1, 32'h5208);
    rc(`AEC_ADDR_MEASURED, 32'h3e8, "measured track");
    cm(32'h2);
    mv(1, 32'h55f0);
    rc(`AEC_ADDR_MEASURED, 32'h3e8, "measured frozen");
    wr(`AEC_ADDR_REF_LEN, 32'h3e9);
    cm(32'h4);
    repeat (4) @(posedge clk_sys_i);
    rc(`AEC_ADDR_PPM, 32'h3e8, "ppm computed");
    chk("corr computed", corr_pos[1], 32'h5606);
    cm(32'h1);
    mv(1, 32'h59d8);
    cm(32'h2);
    wr(`AEC_ADDR_REF_LEN, 32'h3de);
    wr(`AEC_ADDR_STYLUS, 32'ha);
    cm(32'h204);
    repeat (4) @(posedge clk_sys_i);
    rc(`AEC_ADDR_PPM, 32'h0, "ppm stylus");
    chk("corr other axis", corr_pos[2], 32'h4e16);
    wr(`AEC_ADDR_AXIS_SEL, 32'h3);
    wr(`AEC_ADDR_CTRL, 32'h6);
    rc(`AEC_ADDR_CTRL, 32'h4, "nonlinear no mark");
    wr(`AEC_ADDR_CTRL, 32'he);
    mv(3, 32'h100);
    chk("corr before mark", corr_pos[3], 32'h100);
    cm(32'h100);
    rs(32'h0, "export empty");
    cm(32'h80);
    rs(32'h8, "import empty");
    cm(32'h10);
    mv(3, 32'h400);
    rs(32'h4, "mark seen");
    cm(32'h40);
    rc(`AEC_ADDR_DATUM, 32'h400, "datum set");
    pt(32'h3e8, 32'h64);
    wr(`AEC_ADDR_ENTRY_POS, 32'h1f4);
    wr(`AEC_ADDR_ENTRY_ERR, 32'h3e7);
    cm(32'h10);
    rs(32'h104, "cancelled point");
    pt(32'h0, 32'h0);
    rs(32'h204, "two points");
    mv(3, 32'h5f4);
    chk("corr interpolated", corr_pos[3], 32'h626);
    mv(3, 32'hfb8);
    chk("corr above range", corr_pos[3], 32'h101c);
    mv(3, 32'h20c);
    chk("corr below range", corr_pos[3], 32'h20c);
    cm(32'h100);
    rs(32'h214, "export filled");
    rc(`AEC_ADDR_EXP_POS, 32'h0, "first pos");
    rc(`AEC_ADDR_EXP_ERR, 32'h0, "first err");
    rc(`AEC_ADDR_EXP_POS, 32'h3e8, "second pos");
    rc(`AEC_ADDR_EXP_ERR, 32'h64, "second err");
    rs(32'h204, "export done");
    cm(32'h80);
    rs(32'h204, "import filled");
    cm(32'h20);
    repeat (4) @(posedge clk_sys_i);
    rs(32'h4, "cleared");
    rc(`AEC_ADDR_DATUM, 32'h200, "datum at mark");
    cm(32'h40);
    for (int k = 0; k < 129; k++) pt(32'(k * 16), 32'h0);
    rs(32'h8004, "table full");
    end_of_test();
  end
endmodule : axis_error_compensation_bench
